/* File: pkg/fcd_pkg.sv */
// Package: constants and types of the flash command decoder
`default_nettype none
package fcd_pkg;
    localparam int AW = 23;
    localparam int DW = 16;
    localparam int PLANES = 32;
    localparam int PLANE_LSB = 18;
    localparam int OTP_HI_LSB = 9;
    // Command codes, low data byte
    localparam logic [7:0] CMD_READ = 8'hFF;
    localparam logic [7:0] CMD_ERASE_CHIP = 8'h21;
    localparam logic [7:0] CMD_ERASE_PLANE = 8'h22;
    localparam logic [7:0] CMD_ERASE_SECTOR = 8'h20;
    localparam logic [7:0] CMD_CONFIRM = 8'hD0;
    localparam logic [7:0] CMD_PROG_A = 8'h40;
    localparam logic [7:0] CMD_PROG_B = 8'h10;
    localparam logic [7:0] CMD_PROG_DUAL = 8'hE0;
    localparam logic [7:0] CMD_SUSPEND = 8'hB0;
    localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_SOFT_LOCK = 8'h01;
    localparam logic [7:0] CMD_HARD_LOCK = 8'h2F;
    localparam logic [7:0] CMD_CFG_CONFIRM = 8'h03;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLR_STATUS = 8'h50;
    localparam logic [7:0] CMD_OTP_SETUP = 8'hC0;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    // Identification and protection offsets
    localparam logic [7:0] OFS_MFR = 8'h00;
    localparam logic [7:0] OFS_DEV = 8'h01;
    localparam logic [7:0] OFS_BURST_CFG = 8'h05;
    localparam logic [7:0] OFS_PR0_LOCK = 8'h80;
    localparam logic [7:0] OFS_PR_LOCK = 8'h89;
    localparam logic [8:0] OTP_FIRST = 9'h081;
    localparam logic [8:0] OTP_LAST = 9'h109;
    localparam logic [15:0] PR0_LOCK_DATA = 16'hFFFD;
    localparam int PR0_LOCK_BIT = 1;
    // Status bit positions
    localparam int SR_READY = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR = 5;
    localparam int SR_PROG_ERR = 4;
    localparam int SR_VPP_ERR = 3;
    localparam int SR_PROG_SUSP = 2;
    localparam int SR_LOCK_ERR = 1;
    // Reset values
    localparam logic [15:0] BURST_CFG_RST = 16'hB7CF;
    localparam logic [15:0] LOCK_MAP_RST = 16'hFFFF;

    typedef enum logic [3:0] {
        OP_NONE, OP_ERASE_CHIP, OP_ERASE_PLANE, OP_ERASE_SECTOR,
        OP_PROG_WORD, OP_PROG_DUAL, OP_SUSPEND, OP_RESUME,
        OP_SOFT_LOCK, OP_HARD_LOCK, OP_UNLOCK, OP_OTP_PROG
    } fcd_op_e;

    typedef enum logic [1:0] {
        MODE_ARRAY, MODE_STATUS, MODE_ID, MODE_QUERY
    } fcd_mode_e;

    typedef struct packed {
        logic          valid;
        fcd_op_e       op;
        logic [AW-1:0] addr;
        logic [DW-1:0] data0;
        logic [DW-1:0] data1;
    } fcd_cmd_s;

    typedef struct packed {
        logic       wsm_ready;
        logic       erase_susp;
        logic       prog_susp;
        logic       erase_fail;
        logic       prog_fail;
        logic       lock_fail;
        logic       vpp_low;
        logic       vpp_12v;
    } fcd_wsm_s;
endpackage
`default_nettype wire

/* File: rtl/fcd_decoder.sv */
// Command decoder of a parallel NOR flash behind an Avalon-MM slave
//
// Summary of operation
// - Command code from data low byte only
// - ID read offsets compare bits 7:0 only; OTP writes also need bits 22:9 zero
// - Plane taken from address bits 22:18
// - Any word in sector identifies the sector
// - Erase: 21/22/20 then D0
// - Word program: 40 or 10, then data
// - Dual program: E0, two words, 12V only
// - B0 suspends, D0 at plane resumes
// - ID mode: offset 0 maker, 1 device
// - Sector lock: 60 then 01/2F/D0
// - 70 puts plane in status read mode
// - 50 clears status error flags
// - OTP program: C0 then address and data
// - C0 then FFFD at 80 locks user half
// - Zero bits at 89 lock user registers
// - ID read at 80 gives lock in D1
// - ID read at 89 gives 16-bit lock map
// - Burst config: 60 then 03, value on address
// - ID read at offset 005 gives burst config
// - 98 anywhere enters query read mode
// - OTP words span 81 to 109
// - OTP program outside its space is an error
// - Error flags cleared only by 50 or reset
// - FF returns the plane to array read
`default_nettype none
module fcd_decoder #(
    parameter logic [15:0] MFR_CODE = 16'h00A5, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h005A  // Arbitrary value
) (
    // Clock and reset
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    // Avalon-MM slave, the flash command bus
    input  wire logic [fcd_pkg::AW-1:0]  avs_address_i,
    input  wire logic                    avs_read_i,
    input  wire logic                    avs_write_i,
    input  wire logic [fcd_pkg::DW-1:0]  avs_writedata_i,
    output logic      [fcd_pkg::DW-1:0]  avs_readdata_o,
    output logic                         avs_waitrequest_o,
    // Array and query data, write state machine
    input  wire logic [fcd_pkg::DW-1:0]  array_rdata_i,
    input  wire logic [fcd_pkg::DW-1:0]  query_rdata_i,
    input  wire fcd_pkg::fcd_wsm_s       wsm_i,
    // Decoded operations and configuration
    output fcd_pkg::fcd_cmd_s            cmd_o,
    output logic      [fcd_pkg::DW-1:0]  burst_cfg_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_ERASE_CONF, ST_PROG_DATA, ST_DUAL_D0,
        ST_DUAL_D1, ST_LOCK_CONF, ST_OTP_DATA
    } fcd_state_e;

    fcd_state_e             state_q, state_d;
    fcd_pkg::fcd_cmd_s      cmd_q, cmd_d;
    fcd_pkg::fcd_op_e       pend_op_q, pend_op_d;
    logic [fcd_pkg::AW-1:0] pend_addr_q, pend_addr_d;
    logic [fcd_pkg::DW-1:0] pend_data_q, pend_data_d;
    fcd_pkg::fcd_mode_e     mode_q [fcd_pkg::PLANES];
    logic                   wait_q;
    logic [fcd_pkg::DW-1:0] rdata_q;
    logic [fcd_pkg::DW-1:0] cfg_q;
    logic [fcd_pkg::DW-1:0] lock_map_q;
    logic                   pr0_lock_q;
    logic                   sr_erase_q, sr_prog_q, sr_vpp_q, sr_lock_q;
    logic                   seq_err, vpp_err, otp_err;
    logic                   cfg_we, pr0_we, map_we;
    logic [7:0]             status_w;

    logic                   acc, wr, rd, idle_wr, clr, otp_hi_zero;
    logic [7:0]             code, low;
    logic [4:0]             plane;
    logic [8:0]             otp_ofs;

    assign acc = (avs_read_i | avs_write_i) & wait_q;
    assign wr = acc & avs_write_i;
    assign rd = acc & avs_read_i;
    assign code = avs_writedata_i[7:0];
    assign low = avs_address_i[7:0];
    assign plane = avs_address_i[fcd_pkg::AW-1:fcd_pkg::PLANE_LSB];
    assign otp_ofs = avs_address_i[8:0];
    assign otp_hi_zero =
        avs_address_i[fcd_pkg::AW-1:fcd_pkg::OTP_HI_LSB] == '0;
    assign idle_wr = wr & (state_q == ST_IDLE);
    assign clr = idle_wr & (code == fcd_pkg::CMD_CLR_STATUS);

    // Issue helper keeps every decoded operation on one path
    function automatic fcd_pkg::fcd_cmd_s mk(
        input fcd_pkg::fcd_op_e       op,
        input logic [fcd_pkg::AW-1:0] a,
        input logic [fcd_pkg::DW-1:0] d0,
        input logic [fcd_pkg::DW-1:0] d1);
        fcd_pkg::fcd_cmd_s c;
        c.valid = 1'b1;
        c.op = op;
        c.addr = a;
        c.data0 = d0;
        c.data1 = d1;
        return c;
    endfunction

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        cmd_d.valid = 1'b0;
        pend_op_d = pend_op_q;
        pend_addr_d = pend_addr_q;
        pend_data_d = pend_data_q;
        seq_err = 1'b0;
        vpp_err = 1'b0;
        otp_err = 1'b0;
        cfg_we = 1'b0;
        pr0_we = 1'b0;
        map_we = 1'b0;
        if (wr) begin
            unique case (state_q)
                ST_IDLE: begin
                    pend_addr_d = avs_address_i;
                    case (code)
                        fcd_pkg::CMD_ERASE_CHIP: begin
                            pend_op_d = fcd_pkg::OP_ERASE_CHIP;
                            state_d = ST_ERASE_CONF;
                        end
                        fcd_pkg::CMD_ERASE_PLANE: begin
                            pend_op_d = fcd_pkg::OP_ERASE_PLANE;
                            state_d = ST_ERASE_CONF;
                        end
                        fcd_pkg::CMD_ERASE_SECTOR: begin
                            pend_op_d = fcd_pkg::OP_ERASE_SECTOR;
                            state_d = ST_ERASE_CONF;
                        end
                        fcd_pkg::CMD_PROG_A,
                        fcd_pkg::CMD_PROG_B: state_d = ST_PROG_DATA;
                        fcd_pkg::CMD_PROG_DUAL: state_d = ST_DUAL_D0;
                        fcd_pkg::CMD_SUSPEND:
                            cmd_d = mk(fcd_pkg::OP_SUSPEND,
                                       avs_address_i, '0, '0);
                        fcd_pkg::CMD_CONFIRM:
                            cmd_d = mk(fcd_pkg::OP_RESUME,
                                       avs_address_i, '0, '0);
                        fcd_pkg::CMD_LOCK_SETUP: state_d = ST_LOCK_CONF;
                        fcd_pkg::CMD_OTP_SETUP: state_d = ST_OTP_DATA;
                        default: state_d = ST_IDLE;
                    endcase
                end
                ST_ERASE_CONF: begin
                    state_d = ST_IDLE;
                    // Sector held from the first cycle, any word in it
                    if (code == fcd_pkg::CMD_CONFIRM)
                        cmd_d = mk(pend_op_q, pend_addr_q, '0, '0);
                    else
                        seq_err = 1'b1;
                end
                ST_PROG_DATA: begin
                    state_d = ST_IDLE;
                    cmd_d = mk(fcd_pkg::OP_PROG_WORD, avs_address_i,
                               avs_writedata_i, '0);
                end
                ST_DUAL_D0: begin
                    state_d = ST_DUAL_D1;
                    pend_addr_d = avs_address_i;
                    pend_data_d = avs_writedata_i;
                end
                ST_DUAL_D1: begin
                    state_d = ST_IDLE;
                    if (!wsm_i.vpp_12v)
                        vpp_err = 1'b1;
                    else if (avs_address_i[fcd_pkg::AW-1:1] !=
                                 pend_addr_q[fcd_pkg::AW-1:1] ||
                             avs_address_i[0] == pend_addr_q[0])
                        seq_err = 1'b1;
                    else
                        cmd_d = mk(fcd_pkg::OP_PROG_DUAL, pend_addr_q,
                                   pend_data_q, avs_writedata_i);
                end
                ST_LOCK_CONF: begin
                    state_d = ST_IDLE;
                    case (code)
                        fcd_pkg::CMD_SOFT_LOCK:
                            cmd_d = mk(fcd_pkg::OP_SOFT_LOCK,
                                       pend_addr_q, '0, '0);
                        fcd_pkg::CMD_HARD_LOCK:
                            cmd_d = mk(fcd_pkg::OP_HARD_LOCK,
                                       pend_addr_q, '0, '0);
                        fcd_pkg::CMD_CONFIRM:
                            cmd_d = mk(fcd_pkg::OP_UNLOCK,
                                       pend_addr_q, '0, '0);
                        fcd_pkg::CMD_CFG_CONFIRM: cfg_we = 1'b1;
                        default: seq_err = 1'b1;
                    endcase
                end
                ST_OTP_DATA: begin
                    state_d = ST_IDLE;
                    if (otp_hi_zero && low == fcd_pkg::OFS_PR0_LOCK &&
                        avs_writedata_i == fcd_pkg::PR0_LOCK_DATA)
                        pr0_we = 1'b1;
                    else if (otp_hi_zero && low == fcd_pkg::OFS_PR_LOCK)
                        map_we = 1'b1;
                    else if (otp_hi_zero &&
                             otp_ofs >= fcd_pkg::OTP_FIRST &&
                             otp_ofs <= fcd_pkg::OTP_LAST)
                        cmd_d = mk(fcd_pkg::OP_OTP_PROG, avs_address_i,
                                   avs_writedata_i, '0);
                    else
                        otp_err = 1'b1;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_IDLE;
            cmd_q <= '0;
            pend_op_q <= fcd_pkg::OP_NONE;
            pend_addr_q <= '0;
            pend_data_q <= '0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            pend_op_q <= pend_op_d;
            pend_addr_q <= pend_addr_d;
            pend_data_q <= pend_data_d;
        end
    end

    // Sticky errors; a set in the clearing cycle still lands
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sr_erase_q <= 1'b0;
            sr_prog_q <= 1'b0;
            sr_vpp_q <= 1'b0;
            sr_lock_q <= 1'b0;
        end else begin
            sr_erase_q <= (sr_erase_q & ~clr) | wsm_i.erase_fail
                          | seq_err;
            sr_prog_q <= (sr_prog_q & ~clr) | wsm_i.prog_fail
                         | seq_err | otp_err;
            sr_vpp_q <= (sr_vpp_q & ~clr) | wsm_i.vpp_low
                        | vpp_err;
            sr_lock_q <= (sr_lock_q & ~clr) | wsm_i.lock_fail;
        end
    end

    always_comb begin
        status_w = '0;
        status_w[fcd_pkg::SR_READY] = wsm_i.wsm_ready;
        status_w[fcd_pkg::SR_ERASE_SUSP] = wsm_i.erase_susp;
        status_w[fcd_pkg::SR_ERASE_ERR] = sr_erase_q;
        status_w[fcd_pkg::SR_PROG_ERR] = sr_prog_q;
        status_w[fcd_pkg::SR_VPP_ERR] = sr_vpp_q;
        status_w[fcd_pkg::SR_PROG_SUSP] = wsm_i.prog_susp;
        status_w[fcd_pkg::SR_LOCK_ERR] = sr_lock_q;
    end

    // Per-plane read modes
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < fcd_pkg::PLANES; i++)
                mode_q[i] <= fcd_pkg::MODE_ARRAY;
        end else if (idle_wr) begin
            case (code)
                fcd_pkg::CMD_READ:
                    mode_q[plane] <= fcd_pkg::MODE_ARRAY;
                fcd_pkg::CMD_STATUS:
                    mode_q[plane] <= fcd_pkg::MODE_STATUS;
                fcd_pkg::CMD_ID_ENTRY:
                    mode_q[plane] <= fcd_pkg::MODE_ID;
                fcd_pkg::CMD_QUERY:
                    for (int i = 0; i < fcd_pkg::PLANES; i++)
                        mode_q[i] <= fcd_pkg::MODE_QUERY;
                default: ;
            endcase
        end
    end

    // Lock bits only ever go to zero until reset
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pr0_lock_q <= 1'b1;
            lock_map_q <= fcd_pkg::LOCK_MAP_RST;
            cfg_q <= fcd_pkg::BURST_CFG_RST;
        end else begin
            if (pr0_we)
                pr0_lock_q <= 1'b0;
            if (map_we)
                lock_map_q <= lock_map_q & avs_writedata_i;
            if (cfg_we)
                cfg_q <= avs_address_i[15:0];
        end
    end

    // One wait cycle per transfer, answer at the next edge
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
            rdata_q <= '0;
        end else begin
            wait_q <= ~acc;
            if (rd) begin
                unique case (mode_q[plane])
                    fcd_pkg::MODE_ARRAY: rdata_q <= array_rdata_i;
                    fcd_pkg::MODE_STATUS:
                        rdata_q <= {8'h00, status_w};
                    fcd_pkg::MODE_QUERY: rdata_q <= query_rdata_i;
                    fcd_pkg::MODE_ID: begin
                        case (low)
                            fcd_pkg::OFS_MFR: rdata_q <= MFR_CODE;
                            fcd_pkg::OFS_DEV: rdata_q <= DEV_CODE;
                            fcd_pkg::OFS_BURST_CFG:
                                rdata_q <= cfg_q;
                            fcd_pkg::OFS_PR0_LOCK: begin
                                rdata_q <= '0;
                                rdata_q[fcd_pkg::PR0_LOCK_BIT] <=
                                    pr0_lock_q;
                            end
                            fcd_pkg::OFS_PR_LOCK:
                                rdata_q <= lock_map_q;
                            default: rdata_q <= '0;
                        endcase
                    end
                endcase
            end
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;
    assign cmd_o = cmd_q;
    assign burst_cfg_o = cfg_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    a_wait_answer:
        assert property (acc |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("waitrequest not low for exactly one cycle");
    a_erase_issue:
        assert property (wr && state_q == ST_ERASE_CONF &&
                         code == fcd_pkg::CMD_CONFIRM
                         |=> cmd_o.valid && cmd_o.addr == $past(pend_addr_q))
        else $error("erase confirm did not issue");
    a_seq_abort:
        assert property (wr && state_q == ST_ERASE_CONF &&
                         code != fcd_pkg::CMD_CONFIRM
                         |=> !cmd_o.valid && sr_prog_q && sr_erase_q
                             && state_q == ST_IDLE)
        else $error("bad confirm not flagged");
    a_err_sticky:
        assert property (sr_vpp_q && !clr |=> sr_vpp_q)
        else $error("error flag lost without clear");
    a_clear_works:
        assert property (clr && !wsm_i.lock_fail |=> !sr_lock_q)
        else $error("clear status ignored");
    a_dual_vpp:
        assert property (wr && state_q == ST_DUAL_D1 && !wsm_i.vpp_12v
                         |=> !cmd_o.valid && sr_vpp_q)
        else $error("dual program accepted without 12V");
    a_cfg_write:
        assert property (wr && state_q == ST_LOCK_CONF &&
                         code == fcd_pkg::CMD_CFG_CONFIRM
                         |=> burst_cfg_o == $past(avs_address_i[15:0]))
        else $error("burst config not loaded");
    a_otp_range:
        assert property (wr && state_q == ST_OTP_DATA && otp_hi_zero &&
                         low != fcd_pkg::OFS_PR0_LOCK &&
                         low != fcd_pkg::OFS_PR_LOCK &&
                         otp_ofs > fcd_pkg::OTP_LAST |=> sr_prog_q)
        else $error("out of range OTP program not flagged");
    a_id_maker:
        assert property (rd && mode_q[plane] == fcd_pkg::MODE_ID &&
                         low == fcd_pkg::OFS_MFR
                         |=> avs_readdata_o == MFR_CODE)
        else $error("maker code not returned");
endmodule
`default_nettype wire

/* File: tb/fcd_host_model.sv */
// Host bus master model: one Avalon-MM transfer per call
`default_nettype none
module fcd_host_model (
    // Clock
    input  wire logic                   ref_clk_i,
    // Avalon-MM master side
    output logic     [fcd_pkg::AW-1:0]  avs_address_o,
    output logic                        avs_read_o,
    output logic                        avs_write_o,
    output logic     [fcd_pkg::DW-1:0]  avs_writedata_o,
    input  wire logic [fcd_pkg::DW-1:0] avs_readdata_i,
    input  wire logic                   avs_waitrequest_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung;

    initial begin
        hung = 1'b0;
        avs_address_o = 23'h00_0000;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 16'h0000;
    end

    task automatic xfer(input logic rd, input logic [fcd_pkg::AW-1:0] a,
                        input logic [fcd_pkg::DW-1:0] d,
                        output logic [fcd_pkg::DW-1:0] q);
        int n;
        @(posedge ref_clk_i);
        avs_address_o <= a;
        avs_read_o <= rd;
        avs_write_o <= !rd;
        avs_writedata_o <= d;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (avs_waitrequest_i !== 1'b0 && n < 16);
        if (avs_waitrequest_i !== 1'b0) begin
            hung = 1'b1;
        end
        q = avs_readdata_i;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        // Released lines show the inverse, never a stale copy
        avs_address_o <= ~a;
        avs_writedata_o <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: tb/fcd_decoder_bench.sv */
// Self-checking bench of the flash command decoder
`default_nettype none
module fcd_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] ARR = 16'h3C69;
    localparam logic [15:0] QRY = 16'h9A51;
    logic                   ref_clk_i = 1'b0;
    logic                   rst_n_i   = 1'b0;
    logic [fcd_pkg::AW-1:0] address;
    logic                   rd_s;
    logic                   wr_s;
    logic [fcd_pkg::DW-1:0] wdata;
    logic [fcd_pkg::DW-1:0] rdata;
    logic                   wait_s;
    fcd_pkg::fcd_wsm_s      wsm = '0;
    fcd_pkg::fcd_cmd_s      cmd;
    fcd_pkg::fcd_cmd_s      last_cmd;
    logic [fcd_pkg::DW-1:0] burst_cfg;
    logic [fcd_pkg::DW-1:0] q;
    int                     fails = 0;
    int                     compares = 0;
    int                     cmd_cnt = 0;
    int                     exp_cnt = 0;

    always #4 ref_clk_i = ~ref_clk_i;

    fcd_host_model fcd_host_model_i (.ref_clk_i(ref_clk_i),
        .avs_address_o(address), .avs_read_o(rd_s), .avs_write_o(wr_s),
        .avs_writedata_o(wdata), .avs_readdata_i(rdata),
        .avs_waitrequest_i(wait_s));
    fcd_decoder fcd_decoder_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(address), .avs_read_i(rd_s), .avs_write_i(wr_s),
        .avs_writedata_i(wdata), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wait_s), .array_rdata_i(ARR),
        .query_rdata_i(QRY), .wsm_i(wsm), .cmd_o(cmd),
        .burst_cfg_o(burst_cfg));

    always @(posedge ref_clk_i) begin
        if (cmd.valid === 1'b1) begin
            last_cmd <= cmd;
            cmd_cnt <= cmd_cnt + 1;
        end
    end

    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic bus(input logic r, input logic [22:0] a,
                       input logic [15:0] d);
        fcd_host_model_i.xfer(r, a, d, q);
        if (fcd_host_model_i.hung) begin
            fails++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [22:0] a, input logic [15:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rd(input logic [22:0] a);
        bus(1'b1, a, 16'h0000);
    endtask

    task automatic chk_cmd(input fcd_pkg::fcd_op_e op, input logic [22:0] a);
        @(negedge ref_clk_i);
        exp_cnt++;
        chk("cmd count", exp_cnt, cmd_cnt);
        chk("cmd op", 32'(op), 32'(last_cmd.op));
        chk("cmd addr", 32'(a), 32'(last_cmd.addr));
    endtask

    task automatic sr_is(input logic [22:0] a, input logic [7:0] e);
        wr(a, {8'h00, fcd_pkg::CMD_STATUS});
        rd(a);
        chk("status", {8'h00, e}, q);
        chk("cmd count", exp_cnt, cmd_cnt);
    endtask

    // Junk in the upper data byte and high address bits must not matter
    task automatic two_cycle(input logic [7:0] c1, input logic [7:0] c2,
                             input fcd_pkg::fcd_op_e op);
        wr(23'h5A_3C12, {8'hC3, c1});
        wr(23'h5B_FF12, {8'h5A, c2});
        chk_cmd(op, 23'h5A_3C12);
    endtask

    task automatic t_commands();
        chk("burst cfg reset", fcd_pkg::BURST_CFG_RST, burst_cfg);
        rd(23'h12_3456);
        chk("array read", ARR, q);
        two_cycle(8'h21, 8'hD0, fcd_pkg::OP_ERASE_CHIP);
        two_cycle(8'h22, 8'hD0, fcd_pkg::OP_ERASE_PLANE);
        two_cycle(8'h20, 8'hD0, fcd_pkg::OP_ERASE_SECTOR);
        two_cycle(8'h60, 8'h01, fcd_pkg::OP_SOFT_LOCK);
        two_cycle(8'h60, 8'h2F, fcd_pkg::OP_HARD_LOCK);
        two_cycle(8'h60, 8'hD0, fcd_pkg::OP_UNLOCK);
        for (int i = 0; i < 2; i++) begin
            wr(23'h12_3456, {8'h00, i ? 8'h10 : 8'h40});
            wr(23'h12_3456, 16'hBEEF);
            chk_cmd(fcd_pkg::OP_PROG_WORD, 23'h12_3456);
            chk("prog data", 16'hBEEF, last_cmd.data0);
        end
        @(posedge ref_clk_i);
        wsm.vpp_12v <= 1'b1;
        wr(23'h12_3458, {8'h00, fcd_pkg::CMD_PROG_DUAL});
        wr(23'h12_3458, 16'h1111);
        wr(23'h12_3459, 16'h2222);
        chk_cmd(fcd_pkg::OP_PROG_DUAL, 23'h12_3458);
        chk("dual data", 32'h1111_2222,
            {last_cmd.data0, last_cmd.data1});
        wr(23'h00_0000, {8'h00, fcd_pkg::CMD_SUSPEND});
        chk_cmd(fcd_pkg::OP_SUSPEND, 23'h00_0000);
        wr(23'h44_0000, {8'h00, fcd_pkg::CMD_CONFIRM});
        chk_cmd(fcd_pkg::OP_RESUME, 23'h44_0000);
    endtask

    task automatic t_status();
        @(posedge ref_clk_i);
        wsm.wsm_ready <= 1'b1;
        sr_is(23'h24_0000, 8'h80);
        rd(23'h28_0000);
        chk("other plane", ARR, q);
        wr(23'h24_0000, {8'h00, fcd_pkg::CMD_PROG_DUAL});
        wr(23'h24_0000, 16'h0001);
        wr(23'h24_0002, 16'h0002);
        sr_is(23'h27_FFFF, 8'hB0);
        wr(23'h7F_FFFF, {8'h00, fcd_pkg::CMD_CLR_STATUS});
        sr_is(23'h24_0000, 8'h80);
        @(posedge ref_clk_i);
        wsm.vpp_12v <= 1'b0;
        wr(23'h24_0000, {8'h00, fcd_pkg::CMD_PROG_DUAL});
        wr(23'h24_0000, 16'h0001);
        wr(23'h24_0001, 16'h0002);
        sr_is(23'h24_0000, 8'h88);
        wr(23'h24_0000, {8'h00, fcd_pkg::CMD_ERASE_SECTOR});
        wr(23'h24_0000, 16'h0055);
        wr(23'h24_0000, {8'h00, fcd_pkg::CMD_READ});
        sr_is(23'h24_0000, 8'hB8);
        @(posedge ref_clk_i);
        wsm.lock_fail <= 1'b1;
        @(posedge ref_clk_i);
        wsm.lock_fail <= 1'b0;
        sr_is(23'h24_0000, 8'hBA);
        wr(23'h01_0203, {8'h00, fcd_pkg::CMD_CLR_STATUS});
        sr_is(23'h24_0000, 8'h80);
        // Write engine failures pulse once, suspends stay as levels
        @(posedge ref_clk_i);
        wsm <= 8'hFA;
        @(posedge ref_clk_i);
        wsm <= 8'hE0;
        sr_is(23'h24_0000, 8'hFC);
        wr(23'h24_0000, {8'h00, fcd_pkg::CMD_CLR_STATUS});
        sr_is(23'h24_0000, 8'hC4);
        @(posedge ref_clk_i);
        wsm <= 8'h80;
    endtask

    task automatic t_id_otp();
        wr(23'h1C_5A3C, {8'h00, fcd_pkg::CMD_LOCK_SETUP});
        wr(23'h40_5A3C, {8'h00, fcd_pkg::CMD_CFG_CONFIRM});
        @(negedge ref_clk_i);
        chk("burst cfg", 16'h5A3C, burst_cfg);
        wr(23'h1C_0123, {8'h00, fcd_pkg::CMD_ID_ENTRY});
        rd(23'h1C_0000);
        chk("maker code", 16'h00A5, q);
        rd(23'h1D_FF01);
        chk("device code", 16'h005A, q);
        rd(23'h1F_FF05);
        chk("burst cfg read", 16'h5A3C, q);
        // OTP accesses keep address bits 22..9 low
        wr(23'h00_0000, {8'h00, fcd_pkg::CMD_ID_ENTRY});
        rd(23'h00_0080);
        chk("zero lock", 1, q[1]);
        rd(23'h00_0089);
        chk("lock map", 16'hFFFF, q);
        wr(23'h00_0080, {8'h00, fcd_pkg::CMD_OTP_SETUP});
        wr(23'h00_0080, 16'hFFFD);
        rd(23'h00_0080);
        chk("zero lock", 0, q[1]);
        wr(23'h00_0085, {8'h00, fcd_pkg::CMD_OTP_SETUP});
        wr(23'h00_0089, 16'hFF0F);
        rd(23'h00_0089);
        chk("lock map", 16'hFF0F, q);
        for (int i = 0; i < 2; i++) begin
            wr(23'h00_0085, {8'h00, fcd_pkg::CMD_OTP_SETUP});
            wr(i ? 23'h00_0109 : 23'h00_0081, 16'h1234);
            chk_cmd(fcd_pkg::OP_OTP_PROG,
                    i ? 23'h00_0109 : 23'h00_0081);
        end
        wr(23'h00_0085, {8'h00, fcd_pkg::CMD_OTP_SETUP});
        wr(23'h00_010A, 16'h1234);
        sr_is(23'h00_0000, 8'h90);
        wr(23'h00_0000, {8'h00, fcd_pkg::CMD_CLR_STATUS});
    endtask

    task automatic t_query();
        wr(23'h33_3333, {8'h00, fcd_pkg::CMD_QUERY});
        rd(23'h0C_0000);
        chk("query read", QRY, q);
        wr(23'h0C_0042, {8'h00, fcd_pkg::CMD_READ});
        rd(23'h0F_0000);
        chk("array read", ARR, q);
        rd(23'h00_0000);
        chk("query read", QRY, q);
    endtask

    initial begin
        #(8 * 20000);
        fails++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_commands();
        t_status();
        t_id_otp();
        t_query();
        end_of_test();
    end
endmodule
`default_nettype wire
